// [rtl/dct_pkg.sv]
// Package with constants and carrier types for the DRAM reset and termination block.
package dct_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS              = 25000;
  localparam int MODE_UPDATE_DELAY_PS       = 12000;
  localparam int MODE_UPDATE_DELAY_CYC      =
    (MODE_UPDATE_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SYNC_TERM_ON_DELAY_CYC     = 2;
  localparam int SYNC_TERM_OFF_DELAY_CYC    = 2;
  localparam int ASYNC_TERM_ON_WINDOW_CYC   = 1;
  localparam int ASYNC_TERM_OFF_WINDOW_CYC  = 1;
  localparam int TERM_ENTRY_LEAD_MIN_CYC    = 3;
  localparam int TERM_EXIT_LAG_MIN_CYC      = 8;
  localparam int CNT_W                      = 4;

  localparam logic [CNT_W-1:0] MOD_CNT     = CNT_W'(MODE_UPDATE_DELAY_CYC);
  localparam logic [CNT_W-1:0] LEAD_CNT    = CNT_W'(TERM_ENTRY_LEAD_MIN_CYC);
  localparam logic [CNT_W-1:0] LAG_CNT     = CNT_W'(TERM_EXIT_LAG_MIN_CYC);
  localparam logic [CNT_W-1:0] SON_CNT     = CNT_W'(SYNC_TERM_ON_DELAY_CYC);
  localparam logic [CNT_W-1:0] SOFF_CNT    = CNT_W'(SYNC_TERM_OFF_DELAY_CYC);
  localparam logic [CNT_W-1:0] AON_CNT     = CNT_W'(ASYNC_TERM_ON_WINDOW_CYC);
  localparam logic [CNT_W-1:0] AOFF_CNT    = CNT_W'(ASYNC_TERM_OFF_WINDOW_CYC);
  localparam logic [CNT_W-1:0] CNT_ZERO    = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE     = 4'h1;
  localparam logic [CNT_W-1:0] CNT_MAX     = 4'hF;

  // ---------------------------------------------------------------
  // Commands and mode fields
  // ---------------------------------------------------------------
  localparam int ADDR_W        = 14;
  localparam int EXIT_BIT_POS  = 12;
  localparam int RTT_HI_POS    = 6;
  localparam int RTT_LO_POS    = 2;
  localparam logic [1:0] RTT_OFF = 2'h0;

  typedef enum logic [1:0] {
    DCT_REG_MR  = 2'h0,
    DCT_REG_EMR = 2'h1,
    DCT_REG_E2  = 2'h2,
    DCT_REG_E3  = 2'h3
  } dct_reg_sel_t;

  // Command pins: chip select low, row, column and write strobes, all active low.
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } dct_cmd_t;

  localparam logic [3:0] CMD_LOAD_MODE = 4'h0;
  localparam logic [3:0] CMD_REFRESH   = 4'h1;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_ACTIVATE  = 4'h3;
  localparam logic [3:0] CMD_NOP       = 4'h7;

  typedef enum logic [1:0] {
    DCT_CLS_SYNC,
    DCT_CLS_ASYNC
  } dct_class_t;

  typedef struct packed {
    logic       active_on;
    logic [1:0] termination_resistance_setting;
    logic       async_cls;
  } dct_term_t;

endpackage

// [rtl/dct_timer.sv]
// Loadable down counter used for the termination delays.
`timescale 1ns/1ps
module dct_timer
  import dct_pkg::*;
(
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  input  wire logic             load_in,
  input  wire logic [CNT_W-1:0] value_in,
  output logic                  busy_out,
  output logic                  done_out
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  assign cnt_d    = load_in ? value_in : ((cnt_q != CNT_ZERO) ? cnt_q - CNT_ONE : CNT_ZERO);
  assign busy_out = (cnt_q != CNT_ZERO);
  assign done_out = (cnt_q == CNT_ONE);

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= CNT_ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

// [rtl/dct_age.sv]
// Saturating counter of cycles since the last marked event.
`timescale 1ns/1ps
module dct_age
  import dct_pkg::*;
(
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  input  wire logic             mark_in,
  output logic [CNT_W-1:0]      age_out
);

  logic [CNT_W-1:0] age_q;
  logic [CNT_W-1:0] age_d;

  assign age_d   = mark_in ? CNT_ZERO : ((age_q != CNT_MAX) ? age_q + CNT_ONE : CNT_MAX);
  assign age_out = age_q;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      age_q <= CNT_MAX;
    end else begin
      age_q <= age_d;
    end
  end

endmodule

// [rtl/dct_core.sv]
// DRAM clock-enable reset recovery and on-die termination timing core.
`timescale 1ns/1ps
module dct_core
  import dct_pkg::*;
(
  input  wire logic              clk_sys_in,
  input  wire logic              rst_n_in,
  input  wire logic              cke_in,
  input  wire logic              term_pin_in,
  input  wire dct_cmd_t          cmd_in,
  input  wire logic [1:0]        bank_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic              read_pending_in,
  output logic                   term_on_out,
  output logic [1:0]             rtt_out,
  output logic                   term_async_out,
  output logic                   in_reset_out,
  output logic                   powerdown_out,
  output logic                   self_refresh_out,
  output logic                   read_resume_out,
  output logic                   reinit_needed_out
);

  // ---------------------------------------------------------------
  // Device state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_ACTIVE,
    ST_PD_FAST,
    ST_PD_SLOW,
    ST_PD_PRE,
    ST_SELF_REF,
    ST_RESET
  } dct_state_t;

  dct_state_t       state_q;
  dct_state_t       state_d;
  logic             cke_q;
  logic             row_open_q;
  logic             slow_exit_q;
  logic [1:0]       rtt_q;
  logic [1:0]       rtt_pend_q;
  logic             rtt_upd_q;
  logic             term_on_q;
  logic             term_async_q;
  logic             pin_q;
  logic             reinit_q;
  logic             read_cut_q;
  logic             read_resume_q;
  logic             pd_async_q;

  wire logic [3:0] cmd_code  = cmd_in;
  wire logic       cmd_sel   = !cmd_in.cs_n;
  wire logic       is_lm     = cmd_sel && (cmd_code == CMD_LOAD_MODE);
  wire logic       is_ref    = cmd_sel && (cmd_code == CMD_REFRESH);
  wire logic       is_pre    = cmd_sel && (cmd_code == CMD_PRECHARGE);
  wire logic       is_act    = cmd_sel && (cmd_code == CMD_ACTIVATE);
  wire logic       lm_mr     = is_lm && (bank_in == DCT_REG_MR);
  wire logic       lm_emr    = is_lm && (bank_in == DCT_REG_EMR);
  wire logic       cke_fall  = cke_q && !cke_in;
  wire logic       cke_rise  = !cke_q && cke_in;
  wire logic       in_pd     = (state_q == ST_PD_FAST) || (state_q == ST_PD_SLOW)
                               || (state_q == ST_PD_PRE);
  wire logic       in_rst    = (state_q == ST_RESET);
  wire logic       live      = !in_rst && (state_q != ST_SELF_REF);
  wire logic       pin_edge  = live && (term_pin_in != pin_q);

  function automatic logic [1:0] rtt_of(input logic [ADDR_W-1:0] a);
    return {a[RTT_HI_POS], a[RTT_LO_POS]};
  endfunction

  // ---------------------------------------------------------------
  // Helper counters
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] since_entry;
  logic [CNT_W-1:0] since_exit;
  logic [CNT_W-1:0] since_pin;
  logic             mod_busy;
  logic             mod_done;
  logic             sw_busy;
  logic             sw_done;
  logic [CNT_W-1:0] sw_value;
  logic             sw_target_q;

  dct_age u_age_entry (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .mark_in    (cke_fall && !in_rst),
    .age_out    (since_entry)
  );

  dct_age u_age_exit (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .mark_in    (cke_rise && in_pd),
    .age_out    (since_exit)
  );

  dct_age u_age_pin (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .mark_in    (pin_edge),
    .age_out    (since_pin)
  );

  // Update window started by a termination load.
  dct_timer u_mod (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .load_in    (lm_emr && live),
    .value_in   (MOD_CNT),
    .busy_out   (mod_busy),
    .done_out   (mod_done)
  );

  // ---------------------------------------------------------------
  // Timing class selection
  // ---------------------------------------------------------------
  // Async in slow-exit and precharge power-down; synchronous otherwise.
  wire logic mode_async = (state_q == ST_PD_SLOW) || (state_q == ST_PD_PRE);
  // Pin change after entry, within the lead; used only by the c_late_entry cover.
  wire logic late_entry = in_pd && (since_entry < LEAD_CNT) && (since_pin < since_entry);
  // Any power-down exit; turn-on only after slow or precharge exit.
  wire logic early_exit = (state_q == ST_ACTIVE) && (since_exit < LAG_CNT)
                          && (term_pin_in ? pd_async_q : 1'b1);
  // Class picked from enable fall, exit lag and power-down mode.
  wire logic use_async  = mode_async || early_exit || cke_fall;
  // A change inside the lead of entry moves to the async window.
  wire logic pd_entry   = cke_fall && (state_q == ST_ACTIVE) && ((state_d == ST_PD_FAST)
                          || (state_d == ST_PD_SLOW) || (state_d == ST_PD_PRE));
  wire logic late_fall  = pd_entry && (since_pin < LEAD_CNT);
  assign sw_value = use_async ? (term_pin_in ? AON_CNT : AOFF_CNT)
                              : (term_pin_in ? SON_CNT : SOFF_CNT);

  dct_timer u_sw (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .load_in    (pin_edge && rtt_q != RTT_OFF),
    .value_in   (sw_value),
    .busy_out   (sw_busy),
    .done_out   (sw_done)
  );

  // ---------------------------------------------------------------
  // State transitions
  // ---------------------------------------------------------------
  // Reset entered by enable loss mid-operation, left by enable only.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_ACTIVE: begin
        if (cke_fall && is_ref && !row_open_q) begin
          state_d = ST_SELF_REF;
        end else if (cke_fall && (read_pending_in || (cmd_sel && !is_ref))) begin
          state_d = ST_RESET;
        end else if (cke_fall) begin
          state_d = !row_open_q ? ST_PD_PRE : (slow_exit_q ? ST_PD_SLOW : ST_PD_FAST);
        end
      end
      ST_PD_FAST, ST_PD_SLOW, ST_PD_PRE, ST_SELF_REF, ST_RESET: begin
        if (cke_rise) begin
          state_d = ST_ACTIVE;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= ST_ACTIVE;
      cke_q   <= 1'b0;
      pin_q   <= 1'b0;
      pd_async_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cke_q   <= cke_in;
      pin_q   <= live ? term_pin_in : pin_q;
      pd_async_q <= (cke_rise && in_pd) ? mode_async : pd_async_q;
    end
  end

  // Bank and mode tracking; reset drops every open row.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      row_open_q  <= 1'b0;
      slow_exit_q <= 1'b0;
    end else if (state_d == ST_RESET) begin
      row_open_q  <= 1'b0;
      slow_exit_q <= 1'b0;
    end else if (live && cke_q) begin
      row_open_q  <= is_act ? 1'b1 : (is_pre ? 1'b0 : row_open_q);
      slow_exit_q <= lm_mr ? addr_in[EXIT_BIT_POS] : slow_exit_q;
    end
  end

  // Resistance load takes effect when the update window ends.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rtt_q      <= RTT_OFF;
      rtt_pend_q <= RTT_OFF;
      rtt_upd_q  <= 1'b0;
    end else if (state_d == ST_RESET) begin
      rtt_q      <= RTT_OFF;
      rtt_upd_q  <= 1'b0;
    end else begin
      rtt_pend_q <= (lm_emr && live) ? rtt_of(addr_in) : rtt_pend_q;
      rtt_upd_q  <= (lm_emr && live) ? 1'b1 : (mod_done ? 1'b0 : rtt_upd_q);
      rtt_q      <= (mod_done && rtt_upd_q) ? rtt_pend_q : rtt_q;
    end
  end

  // Termination switches when its timer expires.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      term_on_q    <= 1'b0;
      sw_target_q  <= 1'b0;
      term_async_q <= 1'b0;
    end else if (state_d == ST_RESET || rtt_q == RTT_OFF) begin
      term_on_q    <= 1'b0;
      sw_target_q  <= 1'b0;
    end else begin
      sw_target_q  <= pin_edge ? term_pin_in : sw_target_q;
      term_async_q <= pin_edge ? use_async : (late_fall ? 1'b1 : term_async_q);
      term_on_q    <= sw_done ? sw_target_q : term_on_q;
    end
  end

  // Reset loses contents; a cut read may resume on rise.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reinit_q      <= 1'b0;
      read_cut_q    <= 1'b0;
      read_resume_q <= 1'b0;
    end else begin
      reinit_q      <= (state_d == ST_RESET) ? 1'b1 : ((lm_mr && live) ? 1'b0 : reinit_q);
      read_cut_q    <= (state_q == ST_ACTIVE && state_d == ST_RESET) ? read_pending_in
                       : (in_rst ? read_cut_q : 1'b0);
      read_resume_q <= in_rst && cke_rise && read_cut_q;
    end
  end

  assign term_on_out       = term_on_q;
  assign rtt_out           = rtt_q;
  assign term_async_out    = term_async_q;
  assign in_reset_out      = in_rst;
  assign powerdown_out     = in_pd;
  assign self_refresh_out  = (state_q == ST_SELF_REF);
  assign read_resume_out   = read_resume_q;
  assign reinit_needed_out = reinit_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_reset_exit_cke: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (in_rst && !cke_rise) |=> in_rst)
    else $error("reset left without enable rise");
  a_reset_clear_term: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    in_rst |-> !term_on_q && rtt_q == RTT_OFF)
    else $error("termination live in reset");
  a_rtt_update_lat: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (lm_emr && live && state_d != ST_RESET) ##1 (!lm_emr)[*1] |=>
      (rtt_q == $past(rtt_pend_q)) or (lm_emr))
    else $error("resistance not applied on time");
  a_rtt_bits_take: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (lm_emr && live) |=> rtt_pend_q == {$past(addr_in[RTT_HI_POS]), $past(addr_in[RTT_LO_POS])})
    else $error("resistance bits wrong");
  a_class_async_pd: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (pin_edge && mode_async && rtt_q != RTT_OFF && state_d != ST_RESET) |=> term_async_q)
    else $error("async class not used");
  a_class_sync_act: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (pin_edge && !use_async && rtt_q != RTT_OFF && state_d != ST_RESET) |=> !term_async_q)
    else $error("sync class not used");
  a_sync_on_delay: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (pin_edge && term_pin_in && !use_async && rtt_q != RTT_OFF) ##1
      (!pin_edge && rtt_q != RTT_OFF && state_d != ST_RESET)[*2] |=> term_on_q)
    else $error("sync turn-on late");
  a_exit_lag_cls: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (pin_edge && !term_pin_in && early_exit && rtt_q != RTT_OFF) |=> term_async_q)
    else $error("early exit turn-off not async");
  a_resume_read: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    read_resume_q |-> $past(read_cut_q))
    else $error("resume without cut read");
  a_entry_lead_cls: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (late_fall && rtt_q != RTT_OFF) |=> term_async_q)
    else $error("late entry change not async");
  a_async_turn_win: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (pin_edge && use_async && rtt_q != RTT_OFF && state_d != ST_RESET) ##1
      (!pin_edge && rtt_q != RTT_OFF && state_d != ST_RESET) |=> term_on_q == $past(term_pin_in, 2))
    else $error("async switch outside window");
  a_term_off_disabled: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (rtt_q == RTT_OFF) |=> !term_on_q)
    else $error("termination on while disabled");
  a_reinit_flag_set: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (state_d == ST_RESET) |=> reinit_q)
    else $error("reinit flag not set by reset");
  a_resume_one_cycle: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    read_resume_q |=> !read_resume_q)
    else $error("resume pulse too long");
  a_self_ref_quiet: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (state_q == ST_SELF_REF) |=> $stable(pin_q))
    else $error("pin tracked in self refresh");
  a_fast_pd_sync: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (pin_edge && state_q == ST_PD_FAST && rtt_q != RTT_OFF) |=> !term_async_q)
    else $error("fast-exit switch not sync");
  a_exit_on_lag: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (pin_edge && term_pin_in && early_exit && rtt_q != RTT_OFF && state_d != ST_RESET) |=> term_async_q)
    else $error("early exit turn-on not async");

  c_reset_cycle:  cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    in_rst ##[1:20] (state_q == ST_ACTIVE));
  c_rtt_update:   cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    lm_emr ##[1:4] (rtt_q != RTT_OFF));
  c_async_switch: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    pin_edge && mode_async);
  c_late_entry:   cover property (@(posedge clk_sys_in) disable iff (!rst_n_in) late_entry);
  c_self_refresh: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (state_q == ST_SELF_REF) ##1 (state_q == ST_ACTIVE));

endmodule

// [bench/dct_ctl_model.sv]
// Behavioural memory-controller model driving clock enable, termination pin and commands.
`timescale 1ns/1ps
module dct_ctl_model
  import dct_pkg::*;
(
  input  wire logic         clk_sys_in,
  output logic              cke_out,
  output logic              term_pin_out,
  output dct_cmd_t          cmd_out,
  output logic [1:0]        bank_out,
  output logic [ADDR_W-1:0] addr_out,
  output logic              read_pending_out
);
  localparam logic [3:0] IDLE = 4'hF;
  int cyc = 0;
  int pd_edge_cyc = 0;
  int pin_edge_cyc = 0;

  initial begin
    cke_out = 1'b1;
    term_pin_out = 1'b0;
    cmd_out = dct_cmd_t'(IDLE);
    bank_out = 2'h0;
    addr_out = 14'h0000;
    read_pending_out = 1'b0;
  end

  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
  end

  task automatic send_cmd(input logic [3:0] c, input logic [1:0] b, input logic [ADDR_W-1:0] a);
    @(posedge clk_sys_in);
    if (c == CMD_LOAD_MODE) begin
      term_pin_out <= 1'b0;
    end
    cmd_out <= dct_cmd_t'(c);
    bank_out <= b;
    addr_out <= a;
    @(posedge clk_sys_in);
    cmd_out <= dct_cmd_t'(IDLE);
  endtask

  task automatic reinit();
    send_cmd(CMD_LOAD_MODE, 2'h0, 14'h0000);
  endtask

  task automatic set_pin(input logic v);
    @(posedge clk_sys_in);
    term_pin_out <= v;
    pin_edge_cyc = cyc;
  endtask

  task automatic set_cke(input logic v, input logic [3:0] c);
    @(posedge clk_sys_in);
    cke_out <= v;
    cmd_out <= dct_cmd_t'(c);
    pd_edge_cyc = cyc;
    @(posedge clk_sys_in);
    cmd_out <= dct_cmd_t'(IDLE);
    repeat (2) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic set_read(input logic v);
    @(posedge clk_sys_in);
    read_pending_out <= v;
  endtask
endmodule

// [bench/tb_dct_core.sv]
// Self-checking testbench for the reset recovery and termination timing core.
`timescale 1ns/1ps
module tb_dct_core
  import dct_pkg::*;
;
  localparam logic [3:0] DESEL = 4'hF;
  logic              clk_sys_in = 1'b0;
  logic              rst_n_in;
  logic              cke;
  logic              term_pin;
  dct_cmd_t          cmd;
  logic [1:0]        bank;
  logic [ADDR_W-1:0] addr;
  logic              read_pending;
  logic              term_on_out;
  logic [1:0]        rtt_out;
  logic              term_async_out;
  logic              in_reset_out;
  logic              powerdown_out;
  logic              self_refresh_out;
  logic              read_resume_out;
  logic              reinit_needed_out;
  logic              resume_seen = 1'b0;
  int                n_fail = 0;
  int                checks_done = 0;
  int                cycles = 0;

  always #12.5 clk_sys_in = ~clk_sys_in;

  dct_ctl_model ctl (.clk_sys_in(clk_sys_in), .cke_out(cke), .term_pin_out(term_pin),
    .cmd_out(cmd), .bank_out(bank), .addr_out(addr), .read_pending_out(read_pending));

  dct_core dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .cke_in(cke),
    .term_pin_in(term_pin), .cmd_in(cmd), .bank_in(bank), .addr_in(addr),
    .read_pending_in(read_pending), .term_on_out(term_on_out), .rtt_out(rtt_out),
    .term_async_out(term_async_out), .in_reset_out(in_reset_out),
    .powerdown_out(powerdown_out), .self_refresh_out(self_refresh_out),
    .read_resume_out(read_resume_out), .reinit_needed_out(reinit_needed_out));

  // ---------------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------------
  task automatic complete_run();
    if (n_fail == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (read_resume_out === 1'b1) begin
      resume_seen <= 1'b1;
    end
    if (cycles == 3000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge clk_sys_in);
    #1;
  endtask

  // Counts edges until the termination level or the resistance reaches the target.
  task automatic wait_out(input logic sel_rtt, input logic [1:0] target, output logic [15:0] n);
    n = 16'h0000;
    do begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end while ((sel_rtt ? rtt_out : {1'b0, term_on_out}) !== target && n < 16'h0014);
  endtask

  function automatic logic [ADDR_W-1:0] emr_addr(input logic [1:0] v);
    emr_addr = 14'h0000;
    emr_addr[RTT_HI_POS] = v[1];
    emr_addr[RTT_LO_POS] = v[0];
  endfunction

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_rtt_update();
    logic [1:0]  v;
    logic [15:0] n;
    for (int i = 1; i < 5; i++) begin
      v = 2'(i);
      ctl.send_cmd(CMD_LOAD_MODE, 2'h1, emr_addr(v));
      wait_out(1'b1, v, n);
      check("rtt_out", 16'(rtt_out), 16'(v));
      check("rtt delay", n, 16'(MODE_UPDATE_DELAY_CYC));
    end
    ctl.set_pin(1'b1);
    idle(6);
    check("term_on_out disabled", 16'(term_on_out), 16'h0000);
    ctl.send_cmd(CMD_LOAD_MODE, 2'h1, emr_addr(2'h1));
    idle(3);
  endtask

  task automatic t_pd_class();
    logic [15:0] n;
    for (int m = 0; m < 3; m++) begin
      ctl.send_cmd(CMD_LOAD_MODE, 2'h0, (m == 0) ? 14'h0000 : 14'h1000);
      ctl.send_cmd((m == 2) ? CMD_PRECHARGE : CMD_ACTIVATE, 2'h0, 14'h0000);
      ctl.set_cke(1'b0, DESEL);
      check("powerdown_out", 16'(powerdown_out), 16'h0001);
      ctl.set_pin(1'b1);
      wait_out(1'b0, 2'h1, n);
      check("term_async_out", 16'(term_async_out), 16'(m != 0));
      check("on delay", n, 16'((m != 0) ? ASYNC_TERM_ON_WINDOW_CYC + 1
                                        : SYNC_TERM_ON_DELAY_CYC + 1));
      ctl.set_cke(1'b1, DESEL);
      idle(TERM_EXIT_LAG_MIN_CYC + 2);
      ctl.set_pin(1'b0);
      wait_out(1'b0, 2'h0, n);
      check("off delay", n, 16'(SYNC_TERM_OFF_DELAY_CYC + 1));
    end
  endtask

  task automatic t_entry_exit();
    logic [15:0] n;
    ctl.set_pin(1'b1);
    idle(6);
    ctl.set_pin(1'b0);
    idle(TERM_ENTRY_LEAD_MIN_CYC + 1);
    ctl.set_cke(1'b0, DESEL);
    idle(4);
    check("term_on_out lead", 16'(term_on_out), 16'h0000);
    check("term_async_out lead", 16'(term_async_out), 16'h0000);
    ctl.set_cke(1'b1, DESEL);
    idle(TERM_EXIT_LAG_MIN_CYC + 2);
    ctl.set_pin(1'b1);
    ctl.set_cke(1'b0, DESEL);
    idle(4);
    check("term_on_out short lead", 16'(term_on_out), 16'h0001);
    check("term_async_out short lead", 16'(term_async_out), 16'h0001);
    ctl.set_cke(1'b1, DESEL);
    ctl.set_pin(1'b0);
    wait_out(1'b0, 2'h0, n);
    check("term_async_out short lag", 16'(term_async_out), 16'h0001);
    check("off delay short lag", n, 16'(ASYNC_TERM_OFF_WINDOW_CYC + 1));
    idle(TERM_EXIT_LAG_MIN_CYC + 2);
    ctl.set_pin(1'b1);
    wait_out(1'b0, 2'h1, n);
    check("term_async_out lag", 16'(term_async_out), 16'h0000);
    check("on delay lag", n, 16'(SYNC_TERM_ON_DELAY_CYC + 1));
    ctl.set_pin(1'b0);
    idle(6);
  endtask

  task automatic t_reset();
    ctl.set_read(1'b1);
    ctl.set_cke(1'b0, DESEL);
    check("in_reset_out", 16'(in_reset_out), 16'h0001);
    check("reinit_needed_out", 16'(reinit_needed_out), 16'h0001);
    ctl.send_cmd(CMD_LOAD_MODE, 2'h1, emr_addr(2'h3));
    ctl.set_pin(1'b1);
    idle(4);
    check("rtt_out in reset", 16'(rtt_out), 16'h0000);
    check("term_on_out in reset", 16'(term_on_out), 16'h0000);
    ctl.set_pin(1'b0);
    resume_seen = 1'b0;
    ctl.set_cke(1'b1, DESEL);
    ctl.set_read(1'b0);
    idle(2);
    check("read_resume_out", 16'(resume_seen), 16'h0001);
    check("in_reset_out left", 16'(in_reset_out), 16'h0000);
    check("reinit_needed_out held", 16'(reinit_needed_out), 16'h0001);
    ctl.reinit();
    idle(2);
    check("reinit_needed_out done", 16'(reinit_needed_out), 16'h0000);
  endtask

  task automatic t_self_refresh();
    ctl.send_cmd(CMD_LOAD_MODE, 2'h1, emr_addr(2'h2));
    ctl.send_cmd(CMD_PRECHARGE, 2'h0, 14'h0000);
    ctl.set_cke(1'b0, CMD_REFRESH);
    check("self_refresh_out", 16'(self_refresh_out), 16'h0001);
    ctl.set_pin(1'b1);
    idle(5);
    check("term_on_out self refresh", 16'(term_on_out), 16'h0000);
    ctl.set_pin(1'b0);
    ctl.set_cke(1'b1, DESEL);
    check("self_refresh_out exit", 16'(self_refresh_out), 16'h0000);
  endtask

  initial begin
    rst_n_in = 1'b0;
    repeat (12) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    idle(2);
    t_rtt_update();
    t_pd_class();
    t_entry_exit();
    t_reset();
    t_self_refresh();
    complete_run();
  end
endmodule
